// file: oscillation_stabilization_timer.sv
`timescale 1ns/1ps
`include "osc_stab_defs.svh"
module oscillation_stabilization_timer #(
  parameter int CNT_W = `OSC_STAB_CNT_W
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_sys_rst,
  input  wire logic [19:0]           i_addr,
  input  wire logic                  i_wr,
  input  wire logic                  i_wr_byte,
  input  wire osc_stab_pkg::byte_type i_wdata,
  input  wire logic                  i_stop_exec,
  input  wire logic                  i_stop_release,
  input  wire logic                  i_main_osc_halt_wr,
  input  wire logic                  i_crystal_osc_start,
  input  wire logic                  i_crystal_running,
  input  wire logic                  i_cpu_on_crystal,
  output osc_stab_pkg::byte_type     o_rdata,
  output logic                       o_cpu_hold,
  output logic                       o_osc_halt
);
  import osc_stab_pkg::*;

  if (CNT_W < `OSC_STAB_CNT_W) begin
    $error("counter too narrow for longest wait");
  end

  // synchroniser on pin-level crystal running indication
  logic [2:0] run_sync_ff;
  logic [2:0] nxt_run_sync;
  logic       run_ok_ff;
  logic       nxt_run_ok;
  logic       run_ok;
  always_comb begin
    nxt_run_sync = {run_sync_ff[1:0], i_crystal_running};
    nxt_run_ok   = run_ok_ff;
    // a level change counts only once the last two stages agree
    if (run_sync_ff[1] == run_sync_ff[2]) begin
      nxt_run_ok = run_sync_ff[2];
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      run_sync_ff <= 3'h0;
      run_ok_ff   <= 1'b0;
    end else begin
      run_sync_ff <= nxt_run_sync;
      run_ok_ff   <= nxt_run_ok;
    end
  end
  assign run_ok = run_ok_ff;

  function automatic logic [4:0] code_to_exp(input logic [2:0] code);
    case (code)
      3'h0:    code_to_exp = `OSC_STAB_EXP_0;
      3'h1:    code_to_exp = `OSC_STAB_EXP_1;
      3'h2:    code_to_exp = `OSC_STAB_EXP_2;
      3'h3:    code_to_exp = `OSC_STAB_EXP_3;
      3'h4:    code_to_exp = `OSC_STAB_EXP_4;
      3'h5:    code_to_exp = `OSC_STAB_EXP_5;
      3'h6:    code_to_exp = `OSC_STAB_EXP_6;
      default: code_to_exp = `OSC_STAB_EXP_7;
    endcase
  endfunction

  stab_state_type    state_ff, nxt_state;
  logic [CNT_W-1:0]  cnt_ff, nxt_cnt;
  logic [2:0]        sel_ff, nxt_sel;
  byte_type          prog_ff, nxt_prog;
  byte_type          rdata_ff, nxt_rdata;
  logic              hold_ff, nxt_hold;
  logic              halt_ff, nxt_halt;
  logic [CNT_W-1:0]  limit;
  logic              at_limit;
  logic              clr;
  logic [7:0]        passed;

  assign limit    = CNT_W'(1) << code_to_exp(sel_ff);
  assign at_limit = (cnt_ff >= limit);
  assign clr      = i_stop_exec | i_main_osc_halt_wr;

  // one comparator per threshold, bit 7 holds the shortest
  for (genvar g = 0; g < 8; g++) begin : g_threshold
    assign passed[7-g] = (cnt_ff >= (CNT_W'(1) << code_to_exp(3'(g))));
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_sel   = sel_ff;
    nxt_prog  = prog_ff;
    nxt_hold  = hold_ff;
    nxt_halt  = halt_ff;
    // byte-wide write only; progress register ignores writes
    if (i_wr && i_wr_byte && i_addr == `OSC_STAB_SELECT_ADDR) begin
      nxt_sel = i_wdata[`OSC_STAB_CODE_MSB:`OSC_STAB_CODE_LSB];
    end
    case (state_ff)
      ST_IDLE: begin
        if (i_crystal_osc_start) begin
          nxt_state = ST_COUNT;
          nxt_cnt   = '0;
        end
      end
      ST_COUNT: begin
        // no count until the crystal truly oscillates
        if (run_ok) begin
          if (at_limit) begin
            nxt_state = ST_DONE;
            nxt_hold  = 1'b0;
          end else begin
            nxt_cnt = cnt_ff + CNT_W'(1);
          end
        end
      end
      ST_DONE: begin
        if (i_crystal_osc_start) begin
          nxt_state = ST_COUNT;
          nxt_cnt   = '0;
        end
      end
      ST_STOP: begin
        if (i_stop_release) begin
          nxt_halt  = 1'b0;
          nxt_state = ST_COUNT;
          nxt_cnt   = '0;
          nxt_hold  = i_cpu_on_crystal;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    if (i_stop_exec) begin
      nxt_state = ST_STOP;
      nxt_halt  = 1'b1;
      nxt_cnt   = '0;
      nxt_hold  = 1'b0;
    end else if (i_main_osc_halt_wr) begin
      nxt_state = ST_IDLE;
      nxt_cnt   = '0;
    end
    // thermometer from bit 7 down, sticky until cleared
    nxt_prog = nxt_prog | passed;
    if (clr) begin
      nxt_prog = `OSC_STAB_PROGRESS_RST;
    end
    nxt_rdata = 8'h00;
    if (i_addr == `OSC_STAB_PROGRESS_ADDR) begin
      nxt_rdata = nxt_prog;
    end else if (i_addr == `OSC_STAB_SELECT_ADDR) begin
      nxt_rdata = {5'h00, nxt_sel};
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= '0;
      sel_ff   <= 3'(`OSC_STAB_SELECT_RST);
      prog_ff  <= `OSC_STAB_PROGRESS_RST;
      rdata_ff <= 8'h00;
      hold_ff  <= 1'b0;
      halt_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      sel_ff   <= nxt_sel;
      prog_ff  <= nxt_prog;
      rdata_ff <= nxt_rdata;
      hold_ff  <= nxt_hold;
      halt_ff  <= nxt_halt;
    end
  end

  assign o_rdata    = rdata_ff;
  assign o_cpu_hold = hold_ff;
  assign o_osc_halt = halt_ff;

  property p_sel_reset;
    @(posedge i_clk) i_sys_rst |=> sel_ff == 3'h7;
  endproperty
  a_sel_reset: assert property (p_sel_reset) else $error("select not 7 after reset");

  property p_prog_reset;
    @(posedge i_clk) i_sys_rst |=> prog_ff == 8'h00;
  endproperty
  a_prog_reset: assert property (p_prog_reset) else $error("progress not clear");

  property p_clear;
    @(posedge i_clk) disable iff (i_sys_rst) clr |=> prog_ff == 8'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("progress not cleared");

  property p_thermo;
    @(posedge i_clk) disable iff (i_sys_rst)
      prog_ff inside {8'h00, 8'h80, 8'hc0, 8'he0, 8'hf0, 8'hf8, 8'hfc, 8'hfe, 8'hff};
  endproperty
  a_thermo: assert property (p_thermo) else $error("progress not thermometer");

  property p_sticky;
    @(posedge i_clk) disable iff (i_sys_rst)
      !clr |=> (prog_ff & $past(prog_ff)) == $past(prog_ff);
  endproperty
  a_sticky: assert property (p_sticky) else $error("progress bit dropped");

  property p_first_flag;
    @(posedge i_clk) disable iff (i_sys_rst)
      (cnt_ff == 19'h100 && !clr) |=> prog_ff[7];
  endproperty
  a_first_flag: assert property (p_first_flag) else $error("first flag late");

  property p_saturate;
    @(posedge i_clk) disable iff (i_sys_rst)
      (state_ff == ST_COUNT) |-> cnt_ff <= limit;
  endproperty
  a_saturate: assert property (p_saturate) else $error("counter beyond limit");

  property p_no_count_wo_osc;
    @(posedge i_clk) disable iff (i_sys_rst)
      (state_ff == ST_COUNT && !run_ok && !i_stop_exec && !i_main_osc_halt_wr) |=> $stable(cnt_ff);
  endproperty
  a_no_count_wo_osc: assert property (p_no_count_wo_osc) else $error("counted early");

  property p_hold_release;
    @(posedge i_clk) disable iff (i_sys_rst)
      (hold_ff && state_ff == ST_COUNT && run_ok && at_limit && !i_stop_exec) |=> !hold_ff;
  endproperty
  a_hold_release: assert property (p_hold_release) else $error("cpu hold stuck");

  property p_sel_write;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_wr && !i_wr_byte) |=> $stable(sel_ff);
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("bit write changed select");

  property p_halt_on_stop;
    @(posedge i_clk) disable iff (i_sys_rst)
      i_stop_exec |=> halt_ff && state_ff == ST_STOP && cnt_ff == '0;
  endproperty
  a_halt_on_stop: assert property (p_halt_on_stop) else $error("stop not entered");

  property p_release_run;
    @(posedge i_clk) disable iff (i_sys_rst)
      (state_ff == ST_STOP && i_stop_release && !clr) |=> !halt_ff && state_ff == ST_COUNT;
  endproperty
  a_release_run: assert property (p_release_run) else $error("no restart");

  property p_hold_on_release;
    @(posedge i_clk) disable iff (i_sys_rst)
      (state_ff == ST_STOP && i_stop_release && !clr) |=> hold_ff == $past(i_cpu_on_crystal);
  endproperty
  a_hold_on_release: assert property (p_hold_on_release) else $error("hold wrong");

  property p_start_count;
    @(posedge i_clk) disable iff (i_sys_rst)
      (state_ff inside {ST_IDLE, ST_DONE} && i_crystal_osc_start && !clr)
        |=> state_ff == ST_COUNT && cnt_ff == '0;
  endproperty
  a_start_count: assert property (p_start_count) else $error("start ignored");

  property p_sel_byte_write;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_wr && i_wr_byte && i_addr == `OSC_STAB_SELECT_ADDR) |=> sel_ff == 3'($past(i_wdata));
  endproperty
  a_sel_byte_write: assert property (p_sel_byte_write) else $error("no select write");

  property p_count_step;
    @(posedge i_clk) disable iff (i_sys_rst)
      (state_ff == ST_COUNT && run_ok && !at_limit && !clr)
        |=> cnt_ff == $past(cnt_ff) + CNT_W'(1);
  endproperty
  a_count_step: assert property (p_count_step) else $error("count step wrong");

  property p_done_hold;
    @(posedge i_clk) disable iff (i_sys_rst)
      state_ff == ST_DONE |-> !hold_ff;
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("hold after done");

  property p_rdata_prog;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_addr == `OSC_STAB_PROGRESS_ADDR) |=> rdata_ff == prog_ff;
  endproperty
  a_rdata_prog: assert property (p_rdata_prog) else $error("progress read wrong");

  property p_rdata_sel;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_addr == `OSC_STAB_SELECT_ADDR) |=> rdata_ff == {5'h00, sel_ff};
  endproperty
  a_rdata_sel: assert property (p_rdata_sel) else $error("select read wrong");

  property p_idle_still;
    @(posedge i_clk) disable iff (i_sys_rst)
      (state_ff inside {ST_IDLE, ST_DONE} && !i_crystal_osc_start && !clr) |=> $stable(cnt_ff);
  endproperty
  a_idle_still: assert property (p_idle_still) else $error("count moved when idle");

  property p_done_at_limit;
    @(posedge i_clk) disable iff (i_sys_rst)
      (state_ff == ST_COUNT && run_ok && at_limit && !clr) |=> state_ff == ST_DONE;
  endproperty
  a_done_at_limit: assert property (p_done_at_limit) else $error("no stop at limit");

  c_full:    cover property (@(posedge i_clk) prog_ff == 8'hff);
  c_hold:    cover property (@(posedge i_clk) $fell(hold_ff));
  c_stop:    cover property (@(posedge i_clk) state_ff == ST_STOP ##1 state_ff == ST_COUNT);
  c_restart: cover property (@(posedge i_clk) state_ff == ST_DONE ##1 state_ff == ST_COUNT);
endmodule

// file: osc_stab_defs.svh
`ifndef OSC_STAB_DEFS_SVH
`define OSC_STAB_DEFS_SVH
// Summary of operation
// - 8-bit read-only progress register, bit or byte readable.
// - progress register clears to zero on any reset.
// - progress clears on stop instruction and on main oscillator halt write of 1.
// - bits set at 2^8..2^18 crystal cycles, filling from bit 7 down, sticky.
// - counter runs when crystal starts while cpu on internal or subsystem clock.
// - counter runs after stop release with internal clock and crystal enabled.
// - counter stops at selected wait; progress only shows up to it.
// - 8-bit wait select register, written by whole byte only.
// - wait select resets to 07h, the longest wait.
// - codes 0..7 map to 2^8..2^18 cycles; bits 7:3 read zero.
// - with crystal as cpu clock, hold cpu after stop release until wait elapses.
// - count starts only once the crystal actually oscillates.
// - stop state halts main and internal oscillators until release.
`define OSC_STAB_PROGRESS_ADDR  20'hfffa2
`define OSC_STAB_SELECT_ADDR    20'hfffa3
`define OSC_STAB_PROGRESS_RST   8'h00
`define OSC_STAB_SELECT_RST     8'h07
`define OSC_STAB_CODE_MSB       2
`define OSC_STAB_CODE_LSB       0
`define OSC_STAB_CNT_W          19
`define OSC_STAB_EXP_0          5'h08
`define OSC_STAB_EXP_1          5'h09
`define OSC_STAB_EXP_2          5'h0a
`define OSC_STAB_EXP_3          5'h0b
`define OSC_STAB_EXP_4          5'h0d
`define OSC_STAB_EXP_5          5'h0f
`define OSC_STAB_EXP_6          5'h11
`define OSC_STAB_EXP_7          5'h12
`endif

// file: osc_stab_pkg.sv
package osc_stab_pkg;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_COUNT = 2'b01,
    ST_DONE  = 2'b10,
    ST_STOP  = 2'b11
  } stab_state_type;
  typedef logic [7:0] byte_type;
endpackage

// file: crystal_osc_model.sv
`timescale 1ns/1ps
module crystal_osc_model #(
  parameter int STARTUP = 20
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_start,
  input  wire logic i_halt,
  output logic      o_running
);
  logic       en_ff;
  logic [7:0] cnt_ff;
  // dead time before the first swing, which the wait must not include
  always_ff @(posedge i_clk) begin
    if (i_rst) en_ff <= 1'b0;
    else if (i_start) en_ff <= 1'b1;
    if (i_rst || i_halt || !en_ff) cnt_ff <= 8'h00;
    else if (cnt_ff < 8'(STARTUP)) cnt_ff <= cnt_ff + 8'h01;
  end
  assign o_running = en_ff && !i_halt && (cnt_ff == 8'(STARTUP));
endmodule

// file: oscillation_stabilization_timer_tb.sv
`timescale 1ns/1ps
module oscillation_stabilization_timer_tb;
  import osc_stab_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        wr = 1'b0;
  logic        wrb = 1'b0;
  logic [19:0] addr = 20'h00000;
  byte_type    wdata = 8'h00;
  byte_type    rdata;
  logic        stp = 1'b0;
  logic        rel = 1'b0;
  logic        hw = 1'b0;
  logic        go = 1'b0;
  logic        on_x = 1'b0;
  logic        run;
  logic        hold;
  logic        halt;
  int          failures = 0;
  int          num_checks = 0;
  logic [31:0] seed = 32'h0000000c;
  always #5 clk = ~clk;
  crystal_osc_model i_crystal_osc_model (.i_clk(clk), .i_rst(rst), .i_start(go),
    .i_halt(halt), .o_running(run));
  oscillation_stabilization_timer i_oscillation_stabilization_timer (.i_clk(clk),
    .i_sys_rst(rst), .i_addr(addr), .i_wr(wr), .i_wr_byte(wrb), .i_wdata(wdata),
    .i_stop_exec(stp), .i_stop_release(rel), .i_main_osc_halt_wr(hw),
    .i_crystal_osc_start(go), .i_crystal_running(run), .i_cpu_on_crystal(on_x),
    .o_rdata(rdata), .o_cpu_hold(hold), .o_osc_halt(halt));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // thermometer from bit 7 down, one bit per passed threshold
  function automatic byte_type therm(input int code);
    return ~(8'hff >> (code + 1));
  endfunction
  task automatic chk(input string name, input byte_type seen, input byte_type exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr_reg(input logic [19:0] a, input byte_type d, input logic b);
    addr = a;
    wdata = d;
    wrb = b;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
  endtask
  task automatic rd(input logic [19:0] a, output byte_type d);
    addr = a;
    cyc(1);
    d = rdata;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask
  task automatic wait_prog(input byte_type exp);
    addr = 20'hfffa2;
    for (int i = 0; i < 40000; i++) begin
      cyc(1);
      if (rdata === exp) return;
    end
    chk("progress wait", rdata, exp);
    conclude();
  endtask
  initial begin
    byte_type v;
    int code;
    cyc(3);
    rst = 1'b0;
    rd(20'hfffa2, v); chk("progress reset", v, 8'h00);
    rd(20'hfffa3, v); chk("select reset", v, 8'h07);
    wr_reg(20'hfffa2, 8'hff, 1'b1);
    rd(20'hfffa2, v); chk("progress write", v, 8'h00);
    wr_reg(20'hfffa3, 8'h04, 1'b0);
    rd(20'hfffa3, v); chk("select bit write", v, 8'h07);
    rd(20'h00000, v); chk("unmapped read", v, 8'h00);
    seed = xs(seed);
    // codes below 3 give waits under the minimum legal time at 100 MHz
    wr_reg(20'hfffa3, {seed[7:3], 3'h4}, 1'b1);
    rd(20'hfffa3, v); chk("select field", v, 8'h04);
    pulse(go);
    wait_prog(8'h80);
    wait_prog(therm(4));
    cyc(300);
    rd(20'hfffa2, v); chk("saturated", v, therm(4));
    for (int k = 0; k < 3; k++) begin
      seed = xs(seed);
      code = (k == 1) ? 5 : (k == 2) ? 3 : 4;
      wr_reg(20'hfffa3, 8'(code), 1'b1);
      pulse(stp);
      cyc(1);
      chk("halt on stop", {7'h00, halt}, 8'h01);
      rd(20'hfffa2, v); chk("stop clears", v, 8'h00);
      on_x = (k < 2) ? k[0] : seed[1];
      pulse(rel);
      cyc(1);
      chk("hold on release", {7'h00, hold}, {7'h00, on_x});
      chk("halt released", {7'h00, halt}, 8'h00);
      wait_prog(therm(code));
      cyc(2);
      chk("hold dropped", {7'h00, hold}, 8'h00);
    end
    pulse(hw);
    rd(20'hfffa2, v); chk("halt write clears", v, 8'h00);
    wr_reg(20'hfffa3, 8'h04, 1'b1);
    pulse(go);
    wait_prog(8'h80);
    rst = 1'b1;
    cyc(3);
    rst = 1'b0;
    rd(20'hfffa2, v); chk("progress rereset", v, 8'h00);
    rd(20'hfffa3, v); chk("select rereset", v, 8'h07);
    conclude();
  end
endmodule
